// [verilog/mip_core.sv]
// mark interrupt positioning control core
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module mip_core
	import mip_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         markSensorInput,
	input  wire logic         programInterruptMove,
	input  wire logic         moveDone,
	input  wire logic [SPEED_W-1:0] stopDistanceNeed,
	input  wire mip_pkg::mip_motion_t motion,
	input  wire mip_pkg::mip_config_t cfg,
	output mip_pkg::mip_cmd_t cmd,
	output logic              parameterErrorAlarm
);
	import mip_pkg::*;

	// every property below runs on clk and rests while in reset
	default clocking mipCb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------------
	// edge detection and enables
	// ------------------------------------------------------------------
	logic markEdge;
	logic modeOk;
	logic funcOn;
	logic motionOk;
	logic inRange;
	logic signed [POS_W-1:0] relPos;
	logic signed [POS_W-1:0] distance;
	logic signed [POS_W-1:0] signedDist;
	logic steep;
	logic markAccept;
	logic progAccept;

	// command registers, gathered into the command struct below
	logic                     active_reg;
	logic                     active_next;
	logic                     fromMark_reg;
	logic                     fromMark_next;
	logic [POS_W-1:0]         target_reg;
	logic [POS_W-1:0]         target_next;
	logic [SPEED_W-1:0]       holdSpeed_reg;
	logic [SPEED_W-1:0]       holdSpeed_next;
	logic [DECEL_W-1:0]       decelConst_reg;
	logic [DECEL_W-1:0]       decelConst_next;
	logic                     forceSteep_reg;
	logic                     forceSteep_next;
	logic                     overrideEn_reg;
	logic                     pauseEn_reg;
	logic                     speedChangeEn_reg;
	logic                     backlashEn_reg;
	logic                     rollFeedEn_reg;
	logic                     latchEn_reg;
	logic                     reverseMotor_reg;
	logic                     alarm_reg;

	mip_edge_detect u_edge (
		.clk       (clk),
		.reset_n   (reset_n),
		.markIn    (markSensorInput),
		.fallingSel(cfg.markPolarity[POL_FALLING_BIT]),
		.edgePulse (markEdge)
	);

	// mode and function gate
	assign modeOk = (cfg.controlMode == MODE_POINT_TABLE) ||
	                (cfg.controlMode == MODE_PROGRAM);
	assign funcOn = (cfg.markFunction[15:12] == MARK_FN_INTERRUPT);
	// motion states where the mark is meaningless
	assign motionOk = !motion.homing && !motion.manual &&
	                  !motion.stopped && !motion.pauseHold;

	// range relative to start when roll feed shown
	assign relPos = cfg.rollFeed ?
	                $signed(motion.position - motion.startPos) :
	                $signed(motion.position);
	// equal limits open the whole range
	assign inRange = (cfg.rangeUpper == cfg.rangeLower) ||
	                 ((relPos <= cfg.rangeUpper) &&
	                  (relPos >= cfg.rangeLower));

	// six-digit distance: high part times 1000 plus low part
	assign distance = POS_W'(cfg.distHigh * DIGIT_SCALE) +
	                  POS_W'(cfg.distLow);
	// distance follows the present direction of travel
	assign signedDist = motion.reverseDir ? -distance : distance;
	// too short to decelerate at the set constant
	assign steep = (distance < $signed({16'h0000, stopDistanceNeed}));

	// mark accepted only when idle or during a program move
	assign markAccept = markEdge && modeOk && funcOn && motionOk &&
	                    inRange && !cmd.fromMark;
	assign progAccept = programInterruptMove && modeOk && motionOk &&
	                    !cmd.active;

	// ------------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------------
	// sign mismatch of limits is a configuration fault
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			alarm_reg <= 1'b0;
		end else begin
			alarm_reg <= cfg.rangeUpper[POS_W-1] !=
			             cfg.rangeLower[POS_W-1];
		end
	end

	// ------------------------------------------------------------------
	// interrupt move command
	// ------------------------------------------------------------------
	// next command; an accept beats a done in the same cycle
	always_comb begin
		active_next     = active_reg;
		fromMark_next   = fromMark_reg;
		target_next     = target_reg;
		holdSpeed_next  = holdSpeed_reg;
		decelConst_next = decelConst_reg;
		forceSteep_next = forceSteep_reg;
		if (markAccept || progAccept) begin
			active_next     = 1'b1;
			fromMark_next   = markAccept;
			// edge position plus signed distance, taken once
			target_next     = motion.position + signedDist;
			// present speed held, whether accelerating or decelerating
			holdSpeed_next  = motion.speed;
			decelConst_next = motion.decelConst;
			forceSteep_next = steep;
		end else if (moveDone) begin
			// profile resumes per operation mode and pattern
			active_next     = 1'b0;
			fromMark_next   = 1'b0;
			forceSteep_next = 1'b0;
		end
	end

	// captured once per accepted edge; later edges cannot move a mark move's target, but a mark edge replaces a program move's target
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			active_reg     <= 1'b0;
			fromMark_reg   <= 1'b0;
			target_reg     <= POS_ZERO;
			holdSpeed_reg  <= SPEED_ZERO;
			decelConst_reg <= DECEL_ZERO;
			forceSteep_reg <= 1'b0;
		end else begin
			active_reg     <= active_next;
			fromMark_reg   <= fromMark_next;
			target_reg     <= target_next;
			holdSpeed_reg  <= holdSpeed_next;
			decelConst_reg <= decelConst_next;
			forceSteep_reg <= forceSteep_next;
		end
	end

	// ------------------------------------------------------------------
	// function availability
	// ------------------------------------------------------------------
	// a paused interrupt move could overshoot the mark, so disable it
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			overrideEn_reg    <= 1'b1;
			pauseEn_reg       <= 1'b1;
			speedChangeEn_reg <= 1'b1;
			backlashEn_reg    <= 1'b1;
			rollFeedEn_reg    <= 1'b1;
			latchEn_reg       <= 1'b1;
		end else begin
			overrideEn_reg    <= !active_reg ||
			                     (motion.phase == MIP_PH_CONST);
			pauseEn_reg       <= !active_reg;
			speedChangeEn_reg <= !active_reg;
			backlashEn_reg    <= !active_reg;
			rollFeedEn_reg    <= !active_reg;
			latchEn_reg       <= !active_reg;
		end
	end

	// rotation sense from direction select
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			reverseMotor_reg <= 1'b0;
		end else begin
			reverseMotor_reg <= cfg.directionSel;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// every command bit comes straight from its own register
	assign cmd = '{
		active:        active_reg,
		fromMark:      fromMark_reg,
		target:        target_reg,
		holdSpeed:     holdSpeed_reg,
		decelConst:    decelConst_reg,
		forceSteep:    forceSteep_reg,
		overrideEn:    overrideEn_reg,
		pauseEn:       pauseEn_reg,
		speedChangeEn: speedChangeEn_reg,
		backlashEn:    backlashEn_reg,
		rollFeedEn:    rollFeedEn_reg,
		latchEn:       latchEn_reg,
		reverseMotor:  reverseMotor_reg
	};
	assign parameterErrorAlarm = alarm_reg;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_second_edge_ignored: assert property (
		cmd.fromMark && !moveDone |=> $stable(cmd.target))
		else $error("target changed during mark move");
	a_program_blocked: assert property (
		cmd.fromMark && !moveDone && !markEdge |=> cmd.fromMark)
		else $error("program took over a mark move");
	a_gate_homing: assert property (
		!cmd.active && (motion.homing || motion.pauseHold) |=> !cmd.active)
		else $error("move started while blocked");
	a_motion_gate: assert property (
		!cmd.active && (motion.manual || motion.stopped) |=> !cmd.active)
		else $error("move started while jogging or stopped");
	a_mode_gate: assert property (
		!cmd.active && !modeOk |=> !cmd.active)
		else $error("move started in wrong mode");
	a_func_gate: assert property (
		!cmd.active && !funcOn && !programInterruptMove |=> !cmd.active)
		else $error("move started with function off");
	a_target_calc: assert property (
		markAccept |=> cmd.target == $past(motion.position) +
		                             $past(signedDist))
		else $error("wrong target");
	a_alarm_sign: assert property (
		(cfg.rangeUpper[POS_W-1] != cfg.rangeLower[POS_W-1]) |=>
		parameterErrorAlarm)
		else $error("alarm missing");
	a_alarm_clear: assert property (
		(cfg.rangeUpper[POS_W-1] == cfg.rangeLower[POS_W-1]) |=>
		!parameterErrorAlarm)
		else $error("alarm with matching signs");
	a_override_const: assert property (
		cmd.active && motion.phase != MIP_PH_CONST |=> !cmd.overrideEn)
		else $error("override outside constant speed");
	a_pause_off: assert property (
		cmd.active |=> !cmd.pauseEn && !cmd.latchEn)
		else $error("function not disabled");
	a_enables_off: assert property (
		cmd.active |=> !cmd.speedChangeEn && !cmd.backlashEn && !cmd.rollFeedEn)
		else $error("speed change, backlash or roll feed left on");
	a_hold_speed: assert property (
		markAccept |=> cmd.holdSpeed == $past(motion.speed))
		else $error("speed not held");
	a_decel_capture: assert property (
		markAccept || progAccept |=> cmd.decelConst == $past(motion.decelConst))
		else $error("deceleration constant not captured");
	a_steep_capture: assert property (
		markAccept |=> cmd.forceSteep == $past(steep))
		else $error("steep stop flag wrong");
	a_reverse_follow: assert property (
		$past(reset_n) |-> cmd.reverseMotor == $past(cfg.directionSel))
		else $error("rotation sense wrong");
	a_done_clears: assert property (
		moveDone && !markAccept && !progAccept |=> !cmd.active)
		else $error("move did not end");

	c_mark_move: cover property (@(posedge clk) disable iff (!reset_n)
		markAccept);
	c_prog_move: cover property (@(posedge clk) disable iff (!reset_n)
		progAccept);
	c_mark_over_prog: cover property (@(posedge clk) disable iff (!reset_n)
		cmd.active && !cmd.fromMark && markAccept);
	c_steep_stop: cover property (@(posedge clk) disable iff (!reset_n)
		markAccept && steep);
	c_decel_mark: cover property (@(posedge clk) disable iff (!reset_n)
		markAccept && motion.phase == MIP_PH_DECEL);
endmodule

// [verilog/mip_pkg.sv]
// package for the mark interrupt positioning block
package mip_pkg;
	localparam int POS_W = 32;
	localparam int DIST_PART_W = 12;
	localparam int DIGIT_SCALE = 1000;
	localparam logic [3:0] MODE_POINT_TABLE = 4'h6;
	localparam logic [3:0] MODE_PROGRAM = 4'h7;
	localparam logic [3:0] MARK_FN_INTERRUPT = 4'h1;
	localparam int POL_FALLING_BIT = 3;
	localparam int SPEED_W = 16;
	localparam int DECEL_W = 16;
	localparam logic [POS_W-1:0] POS_ZERO = '0;
	localparam logic [SPEED_W-1:0] SPEED_ZERO = '0;
	localparam logic [DECEL_W-1:0] DECEL_ZERO = '0;

	typedef enum logic [1:0] {
		MIP_PH_IDLE,
		MIP_PH_ACCEL,
		MIP_PH_CONST,
		MIP_PH_DECEL
	} mip_phase_t;

	// motion status that the profile generator reports
	typedef struct packed {
		logic               homing;
		logic               manual;
		logic               stopped;
		logic               pauseHold;
		logic [1:0]         phase;
		logic               reverseDir;
		logic [SPEED_W-1:0] speed;
		logic [POS_W-1:0]   position;
		logic [POS_W-1:0]   startPos;
		logic [DECEL_W-1:0] decelConst;
	} mip_motion_t;

	// settings from the configuring host
	typedef struct packed {
		logic [3:0]             controlMode;
		logic [15:0]            markFunction;
		logic [15:0]            markPolarity;
		logic [DIST_PART_W-1:0] distLow;
		logic signed [DIST_PART_W-1:0] distHigh;
		logic signed [POS_W-1:0] rangeUpper;
		logic signed [POS_W-1:0] rangeLower;
		logic                   rollFeed;
		logic                   directionSel;
	} mip_config_t;

	// command to the profile generator
	typedef struct packed {
		logic               active;
		logic               fromMark;
		logic [POS_W-1:0]   target;
		logic [SPEED_W-1:0] holdSpeed;
		logic [DECEL_W-1:0] decelConst;
		logic               forceSteep;
		logic               overrideEn;
		logic               pauseEn;
		logic               speedChangeEn;
		logic               backlashEn;
		logic               rollFeedEn;
		logic               latchEn;
		logic               reverseMotor;
	} mip_cmd_t;
endpackage

// [verilog/mip_edge_detect.sv]
// edge detector for the mark sensor input with selectable polarity
module mip_edge_detect (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic markIn,
	input  wire logic fallingSel,
	output logic      edgePulse
);
	logic prev_reg;

	// previous sample of the mark input
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			// follow the pin in reset so release shows no false edge
			prev_reg <= markIn;
		end else begin
			prev_reg <= markIn;
		end
	end

	// rising when select clear, falling when set
	assign edgePulse = fallingSel ? (prev_reg & ~markIn)
	                              : (~prev_reg & markIn);
endmodule

// [dv/mip_partner.sv]
// mark sensor model giving one pulse of chosen idle level
module mip_partner (
	input  wire logic clk,
	input  wire logic fire,
	input  wire logic idleHigh,
	output logic      markOut
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] width_reg = 2'h0;
	// ------------------------------------------------------------
	// pulse shaper
	// ------------------------------------------------------------
	// three cycles wide so the level is seen on several samples
	always_ff @(posedge clk) begin
		if (fire)
			width_reg <= 2'h3;
		else if (width_reg != 2'h0)
			width_reg <= width_reg - 2'h1;
	end
	assign markOut = idleHigh ^ (width_reg != 2'h0);
endmodule

// [dv/testbench.sv]
// self-checking bench for the mark interrupt positioning core
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mip_pkg::*;
	logic               clk = 1'b0;
	logic               reset_n, fire, idleHigh, prog, moveDone;
	logic               mark, alarm;
	logic [SPEED_W-1:0] stopNeed;
	mip_motion_t        motion;
	mip_config_t        cfg;
	mip_cmd_t           cmd;
	int                 errors = 0;
	int                 checks = 0;
	// ------------------------------------------------------------
	// clock, parts and tasks
	// ------------------------------------------------------------
	initial begin
		forever #5 clk = ~clk;
	end
	mip_partner sensor (.clk(clk), .fire(fire), .idleHigh(idleHigh),
		.markOut(mark));
	mip_core DUT (.clk(clk), .reset_n(reset_n), .markSensorInput(mark),
		.programInterruptMove(prog), .moveDone(moveDone),
		.stopDistanceNeed(stopNeed), .motion(motion), .cfg(cfg),
		.cmd(cmd), .parameterErrorAlarm(alarm));
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up;
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// bounded wait, a hang shows as a mismatch on the flag
	task automatic wait_act(input logic lvl);
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			if (cmd.active === lvl)
				break;
		end
		chk("active", {31'h0, lvl}, {31'h0, cmd.active});
	endtask
	task automatic shot;
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask
	task automatic done;
		@(posedge clk);
		moveDone <= 1'b1;
		@(posedge clk);
		moveDone <= 1'b0;
		wait_act(1'b0);
	endtask
	// fields captured at acceptance, then the enables a cycle on
	task automatic look(input logic fm, input logic [31:0] t,
		input logic st, input logic ov);
		chk("fromMark", fm, cmd.fromMark);
		chk("target", t, cmd.target);
		chk("forceSteep", st, cmd.forceSteep);
		chk("holdSpeed", motion.speed, cmd.holdSpeed);
		chk("decel", motion.decelConst, cmd.decelConst);
		@(negedge clk);
		chk("pauseEn", 1'b0, cmd.pauseEn);
		chk("latchEn", 1'b0, cmd.latchEn);
		chk("speedChangeEn", 1'b0, cmd.speedChangeEn);
		chk("backlashEn", 1'b0, cmd.backlashEn);
		chk("rollFeedEn", 1'b0, cmd.rollFeedEn);
		chk("overrideEn", ov, cmd.overrideEn);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{reset_n, fire, idleHigh, prog, moveDone} = 5'h0;
		stopNeed = 16'h0100;
		motion = '0;
		motion.phase = MIP_PH_CONST;
		motion.position = 32'd100;
		motion.speed = 16'h0200;
		motion.decelConst = 16'h0030;
		cfg = '0;
		cfg.controlMode = MODE_POINT_TABLE;
		cfg.markFunction = 16'h1000;
		cfg.distLow = 12'h005;
		cfg.distHigh = 12'h002;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		chk("rstPause", 1'b1, cmd.pauseEn);
		chk("rstAlarm", 1'b0, alarm);
		chk("rstReverse", 1'b0, cmd.reverseMotor);
		shot();
		wait_act(1'b1);
		look(1'b1, 32'd105 + DIGIT_SCALE * 2, 1'b0, 1'b1);
		// second mark and a program request both refused
		@(posedge clk);
		motion.position <= 32'd500;
		motion.speed <= 16'h0300;
		motion.decelConst <= 16'h0040;
		prog <= 1'b1;
		shot();
		repeat (6) @(negedge clk);
		chk("target", 32'd105 + DIGIT_SCALE * 2, cmd.target);
		chk("fromMark", 1'b1, cmd.fromMark);
		chk("heldSpeed", 16'h0200, cmd.holdSpeed);
		chk("heldDecel", 16'h0030, cmd.decelConst);
		@(posedge clk);
		prog <= 1'b0;
		done();
		// program move in acceleration, short distance
		@(posedge clk);
		motion.phase <= MIP_PH_ACCEL;
		motion.position <= 32'd1000;
		cfg.controlMode <= MODE_PROGRAM;
		cfg.distLow <= 12'h010;
		cfg.distHigh <= 12'h000;
		prog <= 1'b1;
		wait_act(1'b1);
		look(1'b0, 32'd1016, 1'b1, 1'b0);
		@(posedge clk);
		prog <= 1'b0;
		motion.position <= 32'd2000;
		shot();
		repeat (6) @(negedge clk);
		look(1'b1, 32'd2016, 1'b1, 1'b0);
		done();
		// falling edge, reversed direction, in deceleration
		@(posedge clk);
		cfg.markPolarity <= 16'h0008;
		idleHigh <= 1'b1;
		motion.reverseDir <= 1'b1;
		motion.phase <= MIP_PH_DECEL;
		motion.position <= 32'd3000;
		cfg.directionSel <= 1'b1;
		shot();
		wait_act(1'b1);
		look(1'b1, 32'd2984, 1'b1, 1'b0);
		chk("reverse", 1'b1, cmd.reverseMotor);
		done();
		// conditions under which the mark is ignored
		for (int k = 0; k < 7; k++) begin
			@(posedge clk);
			motion.homing <= (k == 0);
			motion.manual <= (k == 1);
			motion.stopped <= (k == 2);
			motion.pauseHold <= (k == 3);
			cfg.controlMode <= (k == 4) ? 4'h5 : MODE_POINT_TABLE;
			cfg.markFunction <= (k == 5) ? 16'h0001 : 16'h1000;
			cfg.rangeUpper <= (k == 6) ? 32'sd500 : 32'sd0;
			cfg.rangeLower <= (k == 6) ? 32'sd300 : 32'sd0;
			shot();
			repeat (6) @(negedge clk);
			chk("ignored", 32'h0, {31'h0, cmd.active});
		end
		// range taken from the start position with roll feed
		@(posedge clk);
		motion.position <= 32'd100;
		motion.startPos <= 32'hffffff06;
		cfg.rollFeed <= 1'b1;
		shot();
		wait_act(1'b1);
		done();
		@(posedge clk);
		cfg.rangeLower <= -32'sd5;
		repeat (3) @(negedge clk);
		chk("alarm", 1'b1, alarm);
		wrap_up();
	end
	// watchdog well past the 106 cycles the tests need
	initial begin
		#50000;
		errors++;
		wrap_up();
	end
endmodule
